// [logic/trq_pkg.sv]
// trq_pkg: constants shared by the ready queue pointer register bank
// assumes a 32-bit axi4-lite register port and 16-bit queue indices
package trq_pkg;

    // ------------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------------
    localparam int TRQ_ADDR_W = 12;
    localparam logic [11:0] TRQ_OFF_START = 12'h328;
    localparam logic [11:0] TRQ_OFF_WRITE = 12'h32c;
    localparam logic [11:0] TRQ_OFF_READ = 12'h330;
    localparam logic [11:0] TRQ_OFF_END = 12'h334;
    localparam logic [11:0] TRQ_OFF_BASE_LO = 12'h340;
    localparam logic [11:0] TRQ_OFF_BASE_HI = 12'h344;

    // ------------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------------
    localparam int TRQ_IDX_W = 16;
    localparam int TRQ_NUM_IDX = 4;
    localparam int TRQ_SEL_START = 0;
    localparam int TRQ_SEL_WRITE = 1;
    localparam int TRQ_SEL_READ = 2;
    localparam int TRQ_SEL_END = 3;
    localparam int TRQ_IDX_SHIFT = 2;
    localparam logic [15:0] TRQ_IDX_RST = 16'h0000;
    localparam logic [15:0] TRQ_IDX_ONE = 16'h0001;
    localparam logic [15:0] TRQ_HALF_RST = 16'h0000;
    localparam logic [31:0] TRQ_BASE_RST = 32'h0000_0000;
    localparam logic [15:0] TRQ_UNUSED_RD = 16'h0000;

    // ------------------------------------------------------------------
    // axi4-lite response codes
    // ------------------------------------------------------------------
    localparam logic [1:0] TRQ_RESP_OKAY = 2'h0;
    localparam logic [1:0] TRQ_RESP_SLVERR = 2'h2;

endpackage : trq_pkg

// [logic/trq_idx_if.sv]
// trq_idx_if: carries base and indices to the address former and back
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface trq_idx_if;
    import trq_pkg::*;

    logic [31:0] base;
    logic [TRQ_NUM_IDX-1:0][TRQ_IDX_W-1:0] idx;
    logic [TRQ_NUM_IDX-1:0][31:0] phys_addr;

    // register bank drives base and indices, reads addresses
    modport bank (
        output base,
        output idx,
        input phys_addr
    );

    // address former reads base and indices, drives addresses
    modport calc (
        input base,
        input idx,
        output phys_addr
    );
endinterface : trq_idx_if

// [logic/trq_addr_calc.sv]
// trq_addr_calc: forms registered physical dword addresses
// assumes base and indices are stable register outputs on aclk
`timescale 1ns/1ps
module trq_addr_calc
    import trq_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    trq_idx_if.calc q
);

    // ------------------------------------------------------------------
    // one adder per index
    // ------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < TRQ_NUM_IDX; i++) begin : g_addr
            logic [31:0] addr_reg;
            logic [31:0] addr_next;
            logic [31:0] scaled;

            // index scaled to a dword offset, bits 17 down to 2
            always_comb begin
                scaled = 32'({q.idx[i], 2'h0});
                addr_next = q.base + scaled;
            end

            // registered so the dma side sees a clean flop output
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    addr_reg <= TRQ_BASE_RST;
                end else begin
                    addr_reg <= addr_next;
                end
            end

            assign q.phys_addr[i] = addr_reg;
        end
    endgenerate

endmodule // trq_addr_calc

// [logic/trq_regs.sv]
// trq_regs: transmit ready queue pointer register bank, axi4-lite slave
// assumes one clock, synchronous active-low reset, host initialises
// all indices and the queue base before the dma side advances pointers
//
// Notes on behaviour
// - start address is start index shifted left two plus queue base
// - write pointer address is write index shifted left two plus base
// - read pointer address is read index shifted left two plus base
// - end address is end index shifted left two plus queue base
// - four read/write 16-bit indices reset to zero, upper bits unused
// - lower base half waits in a holding register until upper half write
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
module trq_regs
    import trq_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [TRQ_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [TRQ_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic wr_ptr_adv,
    input wire logic rd_ptr_adv,
    output logic [31:0] start_addr,
    output logic [31:0] write_addr,
    output logic [31:0] read_addr,
    output logic [31:0] end_addr
);

    // ------------------------------------------------------------------
    // write channel state
    // ------------------------------------------------------------------
    logic aw_full_reg;
    logic aw_full_next;
    logic [TRQ_ADDR_W-1:0] aw_addr_reg;
    logic [TRQ_ADDR_W-1:0] aw_addr_next;
    logic w_full_reg;
    logic w_full_next;
    logic [31:0] w_data_reg;
    logic [31:0] w_data_next;
    logic [3:0] w_strb_reg;
    logic [3:0] w_strb_next;
    logic awready_reg;
    logic awready_next;
    logic wready_reg;
    logic wready_next;
    logic bvalid_reg;
    logic bvalid_next;
    logic [1:0] bresp_reg;
    logic [1:0] bresp_next;
    logic wr_fire;

    // ------------------------------------------------------------------
    // read channel state
    // ------------------------------------------------------------------
    logic arready_reg;
    logic arready_next;
    logic rvalid_reg;
    logic rvalid_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [1:0] rresp_reg;
    logic [1:0] rresp_next;

    // ------------------------------------------------------------------
    // register contents
    // ------------------------------------------------------------------
    logic [TRQ_NUM_IDX-1:0][TRQ_IDX_W-1:0] idx_reg;
    logic [TRQ_NUM_IDX-1:0][TRQ_IDX_W-1:0] idx_next;
    logic [15:0] base_hold_reg;
    logic [15:0] base_hold_next;
    logic [31:0] base_reg;
    logic [31:0] base_next;

    trq_idx_if q_if ();

    // unused protection bits: every access is treated alike
    logic prot_unused;
    assign prot_unused = ^{s_axi_awprot, s_axi_arprot};

    // ------------------------------------------------------------------
    // write path: address and data taken in either order
    // ------------------------------------------------------------------
    // the write lands only once both halves are held and no response
    // is pending, so one write at most is under way
    assign wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;

    always_comb begin
        aw_full_next = aw_full_reg;
        aw_addr_next = aw_addr_reg;
        w_full_next = w_full_reg;
        w_data_next = w_data_reg;
        w_strb_next = w_strb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        if (s_axi_awvalid && awready_reg) begin
            aw_full_next = 1'b1;
            aw_addr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_reg) begin
            w_full_next = 1'b1;
            w_data_next = s_axi_wdata;
            w_strb_next = s_axi_wstrb;
        end
        if (wr_fire) begin
            aw_full_next = 1'b0;
            w_full_next = 1'b0;
            bvalid_next = 1'b1;
            unique case (aw_addr_reg)
                TRQ_OFF_START, TRQ_OFF_WRITE, TRQ_OFF_READ, TRQ_OFF_END,
                TRQ_OFF_BASE_LO, TRQ_OFF_BASE_HI: begin
                    bresp_next = TRQ_RESP_OKAY;
                end
                default: begin
                    bresp_next = TRQ_RESP_SLVERR; // unmapped address
                end
            endcase
        end else if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        // ready comes back only after the response has been taken
        awready_next = !aw_full_next && !bvalid_next;
        wready_next = !w_full_next && !bvalid_next;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_full_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= TRQ_RESP_OKAY;
        end else begin
            aw_full_reg <= aw_full_next;
            aw_addr_reg <= aw_addr_next;
            w_full_reg <= w_full_next;
            w_data_reg <= w_data_next;
            w_strb_reg <= w_strb_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
        end
    end

    // ------------------------------------------------------------------
    // register contents: software writes and pointer advance
    // ------------------------------------------------------------------
    // a software write to a pointer wins over an advance in the same
    // cycle, since the host is reinitialising that pointer
    always_comb begin
        idx_next = idx_reg;
        base_hold_next = base_hold_reg;
        base_next = base_reg;
        // circular advance from the dma side
        if (wr_ptr_adv) begin
            if (idx_reg[TRQ_SEL_WRITE] == idx_reg[TRQ_SEL_END]) begin
                idx_next[TRQ_SEL_WRITE] = idx_reg[TRQ_SEL_START];
            end else begin
                idx_next[TRQ_SEL_WRITE] =
                    idx_reg[TRQ_SEL_WRITE] + TRQ_IDX_ONE;
            end
        end
        if (rd_ptr_adv) begin
            if (idx_reg[TRQ_SEL_READ] == idx_reg[TRQ_SEL_END]) begin
                idx_next[TRQ_SEL_READ] = idx_reg[TRQ_SEL_START];
            end else begin
                idx_next[TRQ_SEL_READ] =
                    idx_reg[TRQ_SEL_READ] + TRQ_IDX_ONE;
            end
        end
        if (wr_fire) begin
            unique case (aw_addr_reg)
                TRQ_OFF_START: begin
                    idx_next[TRQ_SEL_START] = strb_merge(
                        idx_reg[TRQ_SEL_START]);
                end
                TRQ_OFF_WRITE: begin
                    idx_next[TRQ_SEL_WRITE] = strb_merge(
                        idx_reg[TRQ_SEL_WRITE]);
                end
                TRQ_OFF_READ: begin
                    idx_next[TRQ_SEL_READ] = strb_merge(
                        idx_reg[TRQ_SEL_READ]);
                end
                TRQ_OFF_END: begin
                    idx_next[TRQ_SEL_END] = strb_merge(
                        idx_reg[TRQ_SEL_END]);
                end
                TRQ_OFF_BASE_LO: begin
                    // held back so the live base never changes halfway
                    base_hold_next = strb_merge(base_hold_reg);
                end
                TRQ_OFF_BASE_HI: begin
                    base_next = {strb_merge(base_reg[31:16]),
                                 base_hold_reg};
                end
                default: begin
                    base_hold_next = base_hold_reg;
                end
            endcase
        end
    end

    // byte lanes 0 and 1 update, lanes 2 and 3 fall on unused bits
    function automatic logic [15:0] strb_merge(input logic [15:0] old);
        strb_merge = {w_strb_reg[1] ? w_data_reg[15:8] : old[15:8],
                      w_strb_reg[0] ? w_data_reg[7:0] : old[7:0]};
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            idx_reg <= {TRQ_NUM_IDX{TRQ_IDX_RST}};
            base_hold_reg <= TRQ_HALF_RST;
            base_reg <= TRQ_BASE_RST;
        end else begin
            idx_reg <= idx_next;
            base_hold_reg <= base_hold_next;
            base_reg <= base_next;
        end
    end

    // ------------------------------------------------------------------
    // read path: data registered one cycle after the address is taken
    // ------------------------------------------------------------------
    always_comb begin
        arready_next = arready_reg;
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (s_axi_arvalid && arready_reg) begin
            rvalid_next = 1'b1;
            rresp_next = TRQ_RESP_OKAY;
            unique case (s_axi_araddr)
                TRQ_OFF_START: begin
                    rdata_next = {TRQ_UNUSED_RD,
                                  idx_reg[TRQ_SEL_START]};
                end
                TRQ_OFF_WRITE: begin
                    rdata_next = {TRQ_UNUSED_RD,
                                  idx_reg[TRQ_SEL_WRITE]};
                end
                TRQ_OFF_READ: begin
                    rdata_next = {TRQ_UNUSED_RD,
                                  idx_reg[TRQ_SEL_READ]};
                end
                TRQ_OFF_END: begin
                    rdata_next = {TRQ_UNUSED_RD,
                                  idx_reg[TRQ_SEL_END]};
                end
                TRQ_OFF_BASE_LO: begin
                    rdata_next = {TRQ_UNUSED_RD, base_hold_reg};
                end
                TRQ_OFF_BASE_HI: begin
                    rdata_next = {TRQ_UNUSED_RD, base_reg[31:16]};
                end
                default: begin
                    rdata_next = 32'h0000_0000;
                    rresp_next = TRQ_RESP_SLVERR; // unmapped address
                end
            endcase
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
        arready_next = !rvalid_next;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= TRQ_RESP_OKAY;
        end else begin
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

    // ------------------------------------------------------------------
    // address former and outputs
    // ------------------------------------------------------------------
    // base low bits are added as written; alignment is software's duty
    assign q_if.base = base_reg;
    assign q_if.idx = idx_reg;

    trq_addr_calc u_addr_calc (
        .aclk(aclk),
        .aresetn(aresetn),
        .q(q_if.calc)
    );

    // every output below is a flop, here or in the address former
    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign start_addr = q_if.phys_addr[TRQ_SEL_START];
    assign write_addr = q_if.phys_addr[TRQ_SEL_WRITE];
    assign read_addr = q_if.phys_addr[TRQ_SEL_READ];
    assign end_addr = q_if.phys_addr[TRQ_SEL_END];

endmodule // trq_regs

// [verif/trq_props.sv]
// trq_props: bus and address checks on the ready queue pointer bank
// assumes one clock aclk and a synchronous active-low aresetn
`timescale 1ns/1ps
module trq_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic wr_ptr_adv,
    input wire logic rd_ptr_adv,
    input wire logic [31:0] start_addr,
    input wire logic [31:0] write_addr,
    input wire logic [31:0] read_addr,
    input wire logic [31:0] end_addr
);
    // ------------------------
    // assertions
    // ------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
    a_read_latency: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid && !s_axi_arready) else $error("read late");
    a_write_latency: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid && !s_axi_awready
        ##1 s_axi_bvalid) else $error("write answer timing");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("arready during read answer");
    a_aw_blocked: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready) else $error("aw/w reopened");
    a_upper_zero: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
        else $error("upper read bits set");
    // reset must win, so this one is not disabled by it
    a_reset_clear: assert property (disable iff (1'b0)
        !aresetn |=> (start_addr | write_addr | read_addr | end_addr) == 0)
        else $error("addresses not cleared");
    // a step with the bus idle moves the address one dword or wraps it
    a_wr_step: assert property (wr_ptr_adv && s_axi_awready
        |-> ##2 (write_addr == $past(write_addr, 2) + 32'h4 ||
        write_addr == start_addr)) else $error("write step wrong");
    a_rd_step: assert property (rd_ptr_adv && s_axi_awready
        |-> ##2 (read_addr == $past(read_addr, 2) + 32'h4 ||
        read_addr == start_addr)) else $error("read step wrong");
endmodule // trq_props

bind trq_regs trq_props u_props (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .wr_ptr_adv(wr_ptr_adv), .rd_ptr_adv(rd_ptr_adv),
    .start_addr(start_addr), .write_addr(write_addr),
    .read_addr(read_addr), .end_addr(end_addr)
);

// [verif/trq_dma_model.sv]
// trq_dma_model: dma side that steps the write or read pointer
// assumes a request pulse from the bench and a delay of gap cycles
`timescale 1ns/1ps
module trq_dma_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic req_wr,
    input wire logic req_rd,
    input wire logic [3:0] gap,
    output logic wr_ptr_adv,
    output logic rd_ptr_adv
);
    // ------------------------
    // delayed step pulse
    // ------------------------
    logic [4:0] cnt_reg, cnt_next;
    logic wr_reg, wr_next;

    // a slow answer is just a longer count before the pulse
    always_comb begin
        cnt_next = cnt_reg;
        wr_next = wr_reg;
        if (req_wr || req_rd) begin
            cnt_next = {1'b0, gap} + 5'h1;
            wr_next = req_wr;
        end else if (cnt_reg != 5'h0) begin
            cnt_next = cnt_reg - 5'h1;
        end
    end

    // count register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_reg <= 5'h0;
            wr_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            wr_reg <= wr_next;
        end
    end

    // exactly one cycle per step; wrapping is left to the bank
    assign wr_ptr_adv = (cnt_reg == 5'h1) && wr_reg;
    assign rd_ptr_adv = (cnt_reg == 5'h1) && !wr_reg;
endmodule // trq_dma_model

// [verif/testbench.sv]
// testbench: random and corner register traffic into the pointer bank
// assumes trq_regs with its checker bound and the step model beside it
`timescale 1ns/1ps
module testbench;
    import trq_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [11:0] awaddr = 12'h0, araddr = 12'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, req_wr = 1'b0, req_rd = 1'b0;
    logic [3:0] gap = 4'h0;
    logic [31:0] wdata = 32'h0, seed = 32'h712a, base = 32'h0, r;
    logic awready, wready, bvalid, arready, rvalid, wr_adv, rd_adv;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, start_addr, write_addr, read_addr, end_addr, got;
    logic [15:0] idx [0:3] = '{default: 16'h0};
    int n_fail = 0, checks_done = 0, cycles = 0;

    trq_regs uut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .wr_ptr_adv(wr_adv), .rd_ptr_adv(rd_adv),
        .start_addr(start_addr), .write_addr(write_addr),
        .read_addr(read_addr), .end_addr(end_addr)
    );
    trq_dma_model dma (
        .aclk(aclk), .aresetn(aresetn), .req_wr(req_wr), .req_rd(req_rd),
        .gap(gap), .wr_ptr_adv(wr_adv), .rd_ptr_adv(rd_adv)
    );

    // ------------------------
    // helpers
    // ------------------------
    // clock and hang guard
    initial begin
        forever #50 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            conclude();
        end
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [31:0] exp_addr(input int i);
        return base + {14'h0, idx[i], 2'b00};
    endfunction

    task automatic chk(input string what, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        if (n_fail == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // each channel is released at the edge that takes it; the answer's
    // ready rises after a random lag, so the slave must hold its answer
    task automatic axw(input logic [11:0] a, input logic [31:0] d);
        bit fin;
        logic [31:0] lag;
        fin = 0;
        lag = xs() & 32'h3;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1 && bready === 1'b1) begin
                resp = bresp;
                bready <= 1'b0;
                fin = 1;
            end else if (lag == 0) begin
                bready <= 1'b1;
            end else begin
                lag = lag - 1;
            end
        end while (!fin);
    endtask

    task automatic axr(input logic [11:0] a);
        bit fin;
        logic [31:0] lag;
        fin = 0;
        lag = xs() & 32'h3;
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1 && rready === 1'b1) begin
                got = rdata;
                resp = rresp;
                rready <= 1'b0;
                fin = 1;
            end else if (lag == 0) begin
                rready <= 1'b1;
            end else begin
                lag = lag - 1;
            end
        end while (!fin);
    endtask

    // address outputs trail a register write by two edges
    task automatic chk_addr();
        repeat (2) @(posedge aclk);
        chk("start_addr", start_addr, exp_addr(TRQ_SEL_START));
        chk("write_addr", write_addr, exp_addr(TRQ_SEL_WRITE));
        chk("read_addr", read_addr, exp_addr(TRQ_SEL_READ));
        chk("end_addr", end_addr, exp_addr(TRQ_SEL_END));
    endtask

    task automatic set_idx(input int i, input logic [31:0] d);
        axw(TRQ_OFF_START + 12'(4 * i), d);
        chk("bresp", 32'(resp), 32'(TRQ_RESP_OKAY));
        idx[i] = d[15:0];
    endtask

    task automatic rd_idx(input int i);
        axr(TRQ_OFF_START + 12'(4 * i));
        chk("index", got, {16'h0, idx[i]});
    endtask

    task automatic set_base(input logic [31:0] b);
        axw(TRQ_OFF_BASE_LO, {16'h0, b[15:0]});
        chk_addr(); // lower half alone moves nothing
        axw(TRQ_OFF_BASE_HI, {16'h0, b[31:16]});
        base = b;
        chk_addr();
    endtask

    task automatic adv(input bit wr);
        int i;
        i = wr ? TRQ_SEL_WRITE : TRQ_SEL_READ;
        r = xs();
        gap <= r[3:0];
        req_wr <= wr;
        req_rd <= !wr;
        @(posedge aclk);
        req_wr <= 1'b0;
        req_rd <= 1'b0;
        do @(posedge aclk); while (!((wr ? wr_adv : rd_adv) === 1'b1));
        idx[i] = (idx[i] == idx[3]) ? idx[0] : idx[i] + 16'h1;
        chk_addr();
        rd_idx(i);
    endtask

    // ------------------------
    // main sequence
    // ------------------------
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 4; i++) rd_idx(i);
        chk_addr();
        // unmapped place: refused, nothing moves
        axw(12'h338, 32'h0000_1234);
        chk("bresp", 32'(resp), 32'(TRQ_RESP_SLVERR));
        axr(12'h338);
        chk("rdata", got, 32'h0);
        chk("rresp", 32'(resp), 32'(TRQ_RESP_SLVERR));
        chk_addr();
        // first pass uses all-ones to hit the 32-bit carry out
        for (int k = 0; k < 12; k++) begin
            r = (k == 0) ? 32'hffff_fffc : xs();
            set_base({r[31:2], 2'b00});
            for (int i = 0; i < 4; i++) begin
                set_idx(i, (k == 0) ? 32'hffff_ffff : xs());
                rd_idx(i);
            end
        end
        // short ring so both pointers pass the end twice
        set_idx(0, 32'h10);
        set_idx(3, 32'h12);
        set_idx(1, 32'h11);
        set_idx(2, 32'h11);
        for (int k = 0; k < 10; k++) adv(k[0]);
        // second reset in mid-run
        aresetn <= 1'b0;
        @(posedge aclk);
        aresetn <= 1'b1;
        base = 32'h0;
        foreach (idx[i]) idx[i] = 16'h0;
        chk_addr();
        rd_idx(TRQ_SEL_END);
        conclude();
    end
endmodule // testbench
